// ### core/cycle_counter.sv
// Counter that flags when an enable has stood for a given number of clocks
`timescale 1ns/1ps
module cycle_counter #(
  parameter int WIDTH = 8
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic [WIDTH-1:0] limit,
  output logic done
);

  generate
    if (WIDTH < 2 || WIDTH > 16) begin : bad_width
      $error("cycle_counter WIDTH out of range");
    end
  endgenerate

  power_mode_pkg::cnt_state_t state;
  power_mode_pkg::cnt_state_t next_state;

  // Count while run stands, restart from zero as soon as it drops
  always_comb begin
    next_state = state;
    if (!run) begin
      next_state.count = 16'h0000;
      next_state.done = 1'b0;
    end else if (state.count[WIDTH-1:0] != limit) begin
      next_state.count = state.count + 16'h0001;
    end
    next_state.done = run && (next_state.count[WIDTH-1:0] == limit);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign done = state.done;

endmodule : cycle_counter

// ### core/power_mode_control.sv
// Idle and power-down sequencing with the power control register on Avalon-MM
`timescale 1ns/1ps
`include "power_mode_map.svh"
module power_mode_control #(
  parameter int NUM_IRQ = 9,
  parameter int CNT_WIDTH = 8
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Avalon-MM slave, byte addresses
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Interrupt sources and their enables
  input wire logic [NUM_IRQ-1:0] irq_flags,
  input wire logic [NUM_IRQ-1:0] irq_enables,
  input wire logic global_interrupt_enable,
  // Reset sources, active high, synchronous
  input wire logic ext_reset_req,
  input wire logic wdt_reset_req,
  // Controls to the rest of the chip
  output logic cpu_halt,
  output logic twi_halt,
  output logic twi_float,
  output logic pwm_hold_reset,
  output logic pwm_force_high,
  output logic adc_abort,
  output logic clock_halt,
  output logic osc_stop,
  output logic sync_force_high,
  output logic ddc_float,
  output logic core_reset,
  output logic resume_pulse,
  output logic low_voltage_reset_enable,
  output logic low_voltage_level_select
);

  // Hold and restart times in system clocks
  localparam int EXT_HOLD_CLKS = `EXT_RESET_MIN_MC * `MACHINE_CYCLE_CLKS;
  localparam int RESTART_CLKS = `WDT_RESTART_MC * `MACHINE_CYCLE_CLKS;
  localparam logic [CNT_WIDTH-1:0] EXT_LIMIT = CNT_WIDTH'(EXT_HOLD_CLKS - 1);
  localparam logic [CNT_WIDTH-1:0] RESTART_LIMIT = CNT_WIDTH'(RESTART_CLKS - 1);

  generate
    if (NUM_IRQ < 1 || NUM_IRQ > 32) begin : bad_irq
      $error("power_mode_control NUM_IRQ out of range");
    end
    if ((1 << CNT_WIDTH) <= RESTART_CLKS || (1 << CNT_WIDTH) <= EXT_HOLD_CLKS) begin : bad_cnt
      $error("power_mode_control CNT_WIDTH too small");
    end
  endgenerate

  power_mode_pkg::pwr_state_t state;
  power_mode_pkg::pwr_state_t next_state;

  logic ext_reset_held;
  logic restart_done;
  logic bus_req;
  logic bus_take;
  logic [7:0] word_index;
  logic sel_ctrl;
  logic sel_status;
  logic wake_irq;
  logic [7:0] ctrl_written;
  logic [1:0] req_bits;

  // External reset must stand two machine cycles before it counts
  cycle_counter #(
    .WIDTH(CNT_WIDTH)
  ) ext_hold (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .run(ext_reset_req),
    .limit(EXT_LIMIT),
    .done(ext_reset_held)
  );

  // Watchdog restart delay, counted only while restarting
  cycle_counter #(
    .WIDTH(CNT_WIDTH)
  ) wdt_restart (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .run(state.mode == power_mode_pkg::st_restart),
    .limit(RESTART_LIMIT),
    .done(restart_done)
  );

  // Read data image of a register word
  function automatic logic [31:0] read_word(
    input logic is_ctrl,
    input logic is_status,
    input power_mode_pkg::pwr_state_t s
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    if (is_ctrl) begin
      w[7:0] = s.power_control_reg & `PWR_CTRL_USED_MASK;
    end else if (is_status) begin
      w[`PWR_ST_MODE_LSB +: 2] = s.mode;
      w[`PWR_ST_RESET_BIT] = s.core_reset;
      w[`PWR_ST_CLKHALT_BIT] = s.clock_halt;
    end
    return w;
  endfunction : read_word

  // Address decode; unmapped words read zero and ignore writes
  assign bus_req = avs_read | avs_write;
  assign bus_take = bus_req & ~state.waitreq;
  assign word_index = avs_address[9:2];
  assign sel_ctrl = (word_index == `PWR_CTRL_INDEX);
  assign sel_status = (word_index == `PWR_STATUS_INDEX);

  // Wake needs the global enable and the source's own enable
  assign wake_irq = global_interrupt_enable & (|(irq_flags & irq_enables));

  // Value written to the control register, lane zero only
  assign ctrl_written = avs_writedata[7:0] & `PWR_CTRL_USED_MASK;
  assign req_bits = {ctrl_written[`PWR_PDOWN_BIT], ctrl_written[`PWR_IDLE_BIT]};

  // Next state of mode, register and pin controls
  always_comb begin
    next_state = state;
    next_state.adc_abort = 1'b0;
    next_state.resume_pulse = 1'b0;

    // One wait cycle, then the answer with read data ready
    next_state.waitreq = ~(bus_req & state.waitreq);
    if (bus_req && state.waitreq) begin
      next_state.readdata = read_word(sel_ctrl, sel_status, state);
    end

    // Software write to the control register at the answer edge
    if (bus_take && avs_write && sel_ctrl && avs_byteenable[0]) begin
      next_state.power_control_reg = ctrl_written;
      if (req_bits[1]) begin
        // Power-down wins over idle when both are requested
        next_state.mode = power_mode_pkg::st_pdown;
        next_state.power_control_reg[`PWR_IDLE_BIT] = 1'b0;
      end else if (req_bits[0] && state.mode == power_mode_pkg::st_run) begin
        // The setting write is the last instruction before idle
        next_state.mode = power_mode_pkg::st_idle;
        next_state.adc_abort = 1'b1;
      end
    end

    // Idle ends when an enabled interrupt fires
    if (state.mode == power_mode_pkg::st_idle && wake_irq) begin
      next_state.power_control_reg[`PWR_IDLE_BIT] = 1'b0;
      next_state.mode = power_mode_pkg::st_run;
      next_state.resume_pulse = 1'b1;
    end

    // Watchdog keeps running in idle and may restart the core
    if (wdt_reset_req && state.mode != power_mode_pkg::st_pdown) begin
      next_state.mode = power_mode_pkg::st_restart;
      next_state.power_control_reg = `PWR_CTRL_RESET;
    end else if (state.mode == power_mode_pkg::st_restart && restart_done) begin
      next_state.mode = power_mode_pkg::st_run;
    end

    // Only an external reset leaves power-down; it clears the register
    if (ext_reset_held) begin
      next_state.mode = power_mode_pkg::st_run;
      next_state.power_control_reg = `PWR_CTRL_RESET;
    end

    // Pin and block controls follow the next mode
    case (next_state.mode)
      power_mode_pkg::st_idle: begin
        // Core halted, registers and memory simply untouched
        next_state.cpu_halt = 1'b1;
        next_state.twi_halt = 1'b1;
        next_state.twi_float = 1'b1;
        next_state.pwm_hold_reset = 1'b1;
        next_state.pwm_force_high = 1'b1;
        next_state.clock_halt = 1'b0;
        next_state.osc_stop = 1'b0;
        next_state.sync_force_high = 1'b0;
        next_state.ddc_float = 1'b0;
      end
      power_mode_pkg::st_pdown: begin
        // Everything frozen; contents held because nothing is clocked
        next_state.cpu_halt = 1'b1;
        next_state.twi_halt = 1'b1;
        next_state.twi_float = 1'b1;
        next_state.pwm_hold_reset = 1'b1;
        next_state.pwm_force_high = 1'b1;
        next_state.clock_halt = 1'b1;
        next_state.osc_stop = 1'b1;
        next_state.sync_force_high = 1'b1;
        next_state.ddc_float = 1'b1;
      end
      default: begin
        next_state.cpu_halt = 1'b0;
        next_state.twi_halt = 1'b0;
        next_state.twi_float = 1'b0;
        next_state.pwm_hold_reset = 1'b0;
        next_state.pwm_force_high = 1'b0;
        next_state.clock_halt = 1'b0;
        next_state.osc_stop = 1'b0;
        next_state.sync_force_high = 1'b0;
        next_state.ddc_float = 1'b0;
      end
    endcase

    // Core reset while restarting or while a held external reset still stands
    next_state.core_reset = (next_state.mode == power_mode_pkg::st_restart) ||
                            (ext_reset_held && ext_reset_req);

    // Low-voltage reset controls mirror their register bits
    next_state.low_voltage_reset_enable =
      next_state.power_control_reg[`PWR_LVR_EN_BIT];
    next_state.low_voltage_level_select =
      next_state.power_control_reg[`PWR_LEVEL_SEL_BIT];
    // Unused top bits never hold a value
    next_state.power_control_reg[7:6] = 2'b00;
  end

  // Single register stage for the whole state
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= '0;
      state.mode <= power_mode_pkg::st_run;
      state.power_control_reg <= `PWR_CTRL_RESET;
      state.waitreq <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from the state register
  assign avs_readdata = state.readdata;
  assign avs_waitrequest = state.waitreq;
  assign cpu_halt = state.cpu_halt;
  assign twi_halt = state.twi_halt;
  assign twi_float = state.twi_float;
  assign pwm_hold_reset = state.pwm_hold_reset;
  assign pwm_force_high = state.pwm_force_high;
  assign adc_abort = state.adc_abort;
  assign clock_halt = state.clock_halt;
  assign osc_stop = state.osc_stop;
  assign sync_force_high = state.sync_force_high;
  assign ddc_float = state.ddc_float;
  assign core_reset = state.core_reset;
  assign resume_pulse = state.resume_pulse;
  assign low_voltage_reset_enable = state.low_voltage_reset_enable;
  assign low_voltage_level_select = state.low_voltage_level_select;

endmodule : power_mode_control

// ### core/power_mode_map.svh
// Register map, field positions, reset values and timing counts of the power control
//
// Behaviour
// - Bit zero requests idle, bit one power-down.
// - Idle halts core and two-wire serial interface.
// - Idle holds pulse-width channels reset, outputs high.
// - Entering idle aborts a running conversion.
// - Timers, watchdog, data channel, interrupts stay running.
// - Power-down halts system clock and oscillator.
// - Bit five enables low-voltage reset.
// - Bit four selects low-voltage threshold level.
// - Bits three and two are plain flags.
// - Pin states follow the idle/power-down table.
// - Idle-setting write is last instruction before idle.
// - Idle preserves core registers and memory.
// - Enabled interrupt in idle clears idle bit.
// - After wake, execution resumes after setting instruction.
// - Watchdog reset restarts after three machine cycles.
// - Power-down-setting write is last instruction executed.
// - Power-down retains memory and special registers.
// - Only external reset ends power-down, clearing registers.
// - Bits seven and six unused, read zero.
// - Wake needs global and individual enable set.
`ifndef POWER_MODE_MAP_SVH
`define POWER_MODE_MAP_SVH

// Register indices; byte address is four times the index
`define PWR_CTRL_INDEX 8'h87
`define PWR_STATUS_INDEX 8'h88

// Fields of power_control_reg
`define PWR_IDLE_BIT 0
`define PWR_PDOWN_BIT 1
`define PWR_FLAG_ZERO_BIT 2
`define PWR_FLAG_ONE_BIT 3
`define PWR_LEVEL_SEL_BIT 4
`define PWR_LVR_EN_BIT 5
`define PWR_CTRL_USED_MASK 8'h3f
`define PWR_CTRL_RESET 8'h00

// Fields of the status register
`define PWR_ST_MODE_LSB 0
`define PWR_ST_RESET_BIT 2
`define PWR_ST_CLKHALT_BIT 3

// Timing, in system clocks per machine cycle and in machine cycles
`define MACHINE_CYCLE_CLKS 12
`define EXT_RESET_MIN_MC 2
`define WDT_RESTART_MC 3

`endif

// ### core/power_mode_pkg.sv
// Types of the power saving mode control
package power_mode_pkg;

  // Operating mode of the device
  typedef enum logic [1:0] {
    st_run = 2'b00,
    st_idle = 2'b01,
    st_pdown = 2'b10,
    st_restart = 2'b11
  } mode_t;

  // Whole state of the main module
  typedef struct packed {
    mode_t mode;
    logic [7:0] power_control_reg;
    logic waitreq;
    logic [31:0] readdata;
    logic cpu_halt;
    logic twi_halt;
    logic twi_float;
    logic pwm_hold_reset;
    logic pwm_force_high;
    logic adc_abort;
    logic clock_halt;
    logic osc_stop;
    logic sync_force_high;
    logic ddc_float;
    logic core_reset;
    logic resume_pulse;
    logic low_voltage_reset_enable;
    logic low_voltage_level_select;
  } pwr_state_t;

  // State of the cycle counter
  typedef struct packed {
    logic [15:0] count;
    logic done;
  } cnt_state_t;

endpackage : power_mode_pkg

// ### sim/power_mode_props.sv
// Port checker of the power mode control
`timescale 1ns/1ps
`include "power_mode_map.svh"
module power_mode_props #(
  parameter int NUM_IRQ = 9
) (
  input logic sys_clk,
  input logic sys_rst,
  input logic [9:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [3:0] avs_byteenable,
  input logic [31:0] avs_writedata,
  input logic avs_waitrequest,
  input logic [NUM_IRQ-1:0] irq_flags,
  input logic [NUM_IRQ-1:0] irq_enables,
  input logic global_interrupt_enable,
  input logic ext_reset_req,
  input logic wdt_reset_req,
  input logic cpu_halt,
  input logic twi_halt,
  input logic pwm_hold_reset,
  input logic pwm_force_high,
  input logic adc_abort,
  input logic clock_halt,
  input logic osc_stop,
  input logic sync_force_high,
  input logic ddc_float,
  input logic core_reset,
  input logic resume_pulse
);
  localparam logic [9:0] CTRL_ADDR = {`PWR_CTRL_INDEX, 2'b00};
  logic wake;
  logic [5:0] ext_cnt;
  // Wake condition seen at the ports
  assign wake = global_interrupt_enable && (|(irq_flags & irq_enables));
  // Consecutive external reset cycles, saturating so it never wraps
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !ext_reset_req) begin
      ext_cnt <= 6'h00;
    end else if (ext_cnt != 6'h3f) begin
      ext_cnt <= ext_cnt + 6'h01;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Accepted control write, then the mode it finds
  sequence s_wr_ctrl;
    avs_write && !avs_waitrequest && avs_address == CTRL_ADDR && avs_byteenable[0];
  endsequence
  sequence s_enter(logic [1:0] req);
    s_wr_ctrl ##0 (avs_writedata[1:0] == req && !cpu_halt && !core_reset && !clock_halt
      && !wdt_reset_req && !ext_reset_req);
  endsequence
  property p_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  property p_idle;
    s_enter(2'b01) ##0 !wake |=> cpu_halt && twi_halt && pwm_hold_reset && pwm_force_high
      && adc_abort;
  endproperty
  property p_abort;
    adc_abort |=> !adc_abort;
  endproperty
  property p_wake;
    cpu_halt && !clock_halt && !core_reset && wake |=> !cpu_halt && resume_pulse;
  endproperty
  property p_pdown;
    s_enter(2'b11) |=> clock_halt && osc_stop && sync_force_high && ddc_float;
  endproperty
  property p_pd_stay;
    clock_halt && !ext_reset_req |=> clock_halt && !resume_pulse;
  endproperty
  property p_wdt;
    wdt_reset_req && !clock_halt && !core_reset |-> ##[1:2] core_reset [*8];
  endproperty
  property p_ext;
    ext_cnt >= 6'h1a |-> core_reset && !clock_halt;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");
  a_idle: assert property (p_idle) else $error("idle not entered");
  a_abort: assert property (p_abort) else $error("abort not a pulse");
  a_wake: assert property (p_wake) else $error("wake missed");
  a_pdown: assert property (p_pdown) else $error("power-down not entered");
  a_pd_stay: assert property (p_pd_stay) else $error("power-down left");
  a_wdt: assert property (p_wdt) else $error("restart too short");
  a_ext: assert property (p_ext) else $error("external reset missed");
endmodule : power_mode_props

bind power_mode_control power_mode_props #(.NUM_IRQ(NUM_IRQ)) u_props (.*);

// ### sim/tb.sv
// Self-checking bench of the power mode control
`timescale 1ns/1ps
`include "power_mode_map.svh"
module tb;
  localparam logic [9:0] CA = {`PWR_CTRL_INDEX, 2'b00};
  localparam logic [9:0] SA = {`PWR_STATUS_INDEX, 2'b00};
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'h1;
  logic [31:0] avs_writedata = 32'h0;
  logic [8:0] irq_flags = 9'h000;
  logic [8:0] irq_enables = 9'h000;
  logic global_interrupt_enable = 1'b0;
  logic ext_reset_req = 1'b0;
  logic wdt_reset_req = 1'b0;
  logic [31:0] avs_readdata, rdata;
  logic avs_waitrequest, cpu_halt, twi_halt, twi_float, pwm_hold_reset, pwm_force_high;
  logic adc_abort, clock_halt, osc_stop, sync_force_high, ddc_float, core_reset;
  logic resume_pulse, low_voltage_reset_enable, low_voltage_level_select;
  int err_total = 0;
  int total_checks = 0;

  power_mode_control dut (.*);

  // Free-running system clock
  always #12.5 sys_clk = ~sys_clk;

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One bus cycle, held until waitrequest is seen low
  task bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    chk("waitrequest", 32'h0, {31'h0, avs_waitrequest});
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task rd(input logic [9:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rdata);
  endtask : rd

  task print_verdict();
    if (err_total == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end

  // Main sequence
  initial begin
    int n;
    int m;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(CA, 32'h0, "ctrl reset");
    rd(SA, 32'h0, "status reset");
    avs_byteenable <= 4'h0;
    bus(1'b1, CA, 32'hff);
    avs_byteenable <= 4'h1;
    rd(CA, 32'h0, "lane off");
    rd(10'h000, 32'h0, "unmapped");
    bus(1'b1, 10'h000, 32'h3f);
    rd(CA, 32'h0, "unmapped write");
    bus(1'b1, CA, 32'hfc);
    rd(CA, 32'h3c, "ctrl flags");
    chk("lvr on", 32'h3, {30'h0, low_voltage_reset_enable, low_voltage_level_select});
    bus(1'b1, CA, 32'h0c);
    rd(CA, 32'h0c, "ctrl flags 2");
    chk("lvr off", 32'h0, {30'h0, low_voltage_reset_enable, low_voltage_level_select});
    // Idle entry, masked wake, then enabled wake
    bus(1'b1, CA, 32'h3d);
    // Abort pulse stands only in the cycle after the answer edge
    #1;
    chk("idle halts", 32'h3f, {26'h0, cpu_halt, twi_halt, twi_float, pwm_hold_reset,
      pwm_force_high, adc_abort});
    chk("idle pins", 32'h0, {28'h0, clock_halt, osc_stop, sync_force_high, ddc_float});
    @(posedge sys_clk);
    #1;
    chk("abort pulse", 32'h0, {31'h0, adc_abort});
    rd(SA, 32'h1, "status idle");
    irq_flags <= 9'h100;
    irq_enables <= 9'h100;
    repeat (4) @(posedge sys_clk);
    #1;
    chk("no wake", 32'h1, {31'h0, cpu_halt});
    @(posedge sys_clk);
    global_interrupt_enable <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk("wake", 32'h1, {30'h0, cpu_halt, resume_pulse});
    @(posedge sys_clk);
    global_interrupt_enable <= 1'b0;
    irq_flags <= 9'h000;
    rd(CA, 32'h3c, "idle cleared");
    // Both requests: power-down wins, only external reset ends it
    bus(1'b1, CA, 32'h03);
    @(posedge sys_clk);
    #1;
    chk("pdown pins", 32'hf, {28'h0, clock_halt, osc_stop, sync_force_high, ddc_float});
    rd(SA, 32'ha, "status pdown");
    @(posedge sys_clk);
    irq_flags <= 9'h100;
    global_interrupt_enable <= 1'b1;
    wdt_reset_req <= 1'b1;
    @(posedge sys_clk);
    wdt_reset_req <= 1'b0;
    repeat (5) @(posedge sys_clk);
    #1;
    chk("pdown holds", 32'h4, {29'h0, clock_halt, core_reset, resume_pulse});
    @(posedge sys_clk);
    irq_flags <= 9'h000;
    global_interrupt_enable <= 1'b0;
    ext_reset_req <= 1'b1;
    repeat (30) @(posedge sys_clk);
    ext_reset_req <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("ext reset", 32'h0, {29'h0, clock_halt, core_reset, cpu_halt});
    rd(CA, 32'h0, "ctrl cleared");
    // Watchdog in idle: restart length counted in clocks
    bus(1'b1, CA, 32'h01);
    @(posedge sys_clk);
    wdt_reset_req <= 1'b1;
    @(posedge sys_clk);
    wdt_reset_req <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (core_reset !== 1'b1 && n < 10);
    m = 0;
    while (core_reset === 1'b1 && m < 100) begin
      @(posedge sys_clk);
      m++;
    end
    chk("restart len", `WDT_RESTART_MC * `MACHINE_CYCLE_CLKS, m);
    rd(CA, 32'h0, "restart clears");
    rd(SA, 32'h0, "status run");
    print_verdict();
  end
endmodule : tb
